// ==== design/weld_pkg.sv ====
package weld_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL = 5'h00; // process, regulation, display
    localparam logic [4:0] ADDR_TIMES = 5'h04; // squeeze, weld, hold counts
    localparam logic [4:0] ADDR_CURRENT = 5'h08; // set point and limits
    localparam logic [4:0] ADDR_STATUS = 5'h0C; // read only state view
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10; // sticky, write one clears
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h14; // same layout as status

    // ----------------------------------------------------------------
    // field positions and codes
    // ----------------------------------------------------------------
    localparam int CTRL_SHOW_PCT_BIT = 16; // display percent current
    localparam logic [7:0] PO_HOLD_PART = 8'h26; // hold part out of window
    localparam logic [7:0] PO_HALF_CYCLE = 8'h09; // half-cycle welding
    localparam logic [7:0] CR_NONE = 8'h00; // no current sensor selected
    localparam logic [7:0] LIMIT_DEFAULT = 8'h00; // limit left unset
    localparam int LIMIT_DEFAULT_DIV = 10; // default window of ten percent
    localparam int IRQ_WELD_DONE = 0; // sequence finished
    localparam int IRQ_CUR_ERROR = 1; // current outside window
    localparam int IRQ_ERR_CLEARED = 2; // operator acknowledged error
    localparam int IRQ_BITS = 3;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] TIMES_RESET = 32'h0000_0000;
    localparam logic [31:0] CURRENT_RESET = 32'h0000_0000;
    localparam int CLK_HZ = 250_000_000; // core clock rate
    localparam int MAINS_HZ = 60; // mains frequency
    localparam int HALF_CYCLE_CLKS = CLK_HZ / (2 * MAINS_HZ); // rounds down

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SQUEEZE = 3'b001,
        ST_WELD = 3'b011,
        ST_HOLD = 3'b010,
        ST_HELD = 3'b110,
        ST_POR = 3'b111
    } seq_state_e;

    typedef struct packed {
        logic show_pct; // display measured current after each weld
        logic [7:0] reg_sel; // current regulation / sensor code
        logic [7:0] proc_out; // process output selection
    } ctrl_s;

    typedef struct packed {
        logic electrode_valve; // welding head solenoid
        logic isolation_relay; // transformer isolation contactor
        logic alarm_relay; // alarm lamp or controller input
        logic weld_fire; // thyristor firing enable
    } valves_s;
endpackage : weld_pkg

// ==== design/weld_current_limit_hold_sequencer.sv ====
// Notes on behaviour
// [RQ1] process 26 clamps part when current out of window
// [RQ2] valve one electrode, two isolation, three alarm
// [RQ3] electrode stays on if out of window
// [RQ4] schedule uses valve mode 03 for both valves
// [RQ5] isolation only during squeeze, weld and hold
// [RQ6] alarm on while part is held
// [RQ7] electrode and alarm hold until panel acknowledge
// [RQ8] lockout key must be turned before clearing; the code asks for the turned key only while lockout_key_fitted is high
// [RQ9] isolation drops at end of hold regardless
// [RQ10] clearing drops all valves then power-on reset
// [RQ11] process code 09 enables half-cycle welding
// [RQ12] half-cycle schedule: weld 01, off zero
// [RQ13] monitoring enabled by nonzero sensor code
// [RQ14] percent display shows measured current after weld
// [RQ15] zero limits default to plus/minus ten percent
// [RQ16] current error blocks further initiations
// [RQ17] alarm asserts at once on error detection
// [RQ18] current equal to a limit is in window
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module weld_current_limit_hold_sequencer #(
    parameter int HALF_CYCLE_DIV = weld_pkg::HALF_CYCLE_CLKS,
    parameter int CUR_W = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // machine side
    input wire logic initiate,
    input wire logic [CUR_W-1:0] measured_current,
    input wire logic current_valid,
    input wire logic panel_button,
    input wire logic lockout_key_fitted,
    input wire logic lockout_key_turned,
    output weld_pkg::valves_s valves,
    output logic [CUR_W-1:0] display_value,
    output logic irq
);
    import weld_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // effective limit: zero selects set point plus or minus a tenth
    function automatic logic [CUR_W:0] eff_limit(
        input logic [CUR_W-1:0] lim, input logic [CUR_W-1:0] set,
        input logic upper);
        logic [CUR_W:0] tenth;
        tenth = (CUR_W+1)'(set / LIMIT_DEFAULT_DIV);
        if (lim != CUR_W'(LIMIT_DEFAULT)) begin
            eff_limit = {1'b0, lim};
        end else if (upper) begin
            eff_limit = {1'b0, set} + tenth; // [RQ15]
        end else begin
            eff_limit = {1'b0, set} - tenth; // [RQ15]
        end
    endfunction : eff_limit

    // ----------------------------------------------------------------
    // register and bus state
    // ----------------------------------------------------------------
    ctrl_s ctrl, next_ctrl; // process and display selections
    logic [23:0] times, next_times; // squeeze, weld, hold in cycles
    logic [23:0] cur_cfg, next_cur_cfg; // set, high, low
    logic [IRQ_BITS-1:0] irq_stat, next_irq_stat; // sticky events
    logic [IRQ_BITS-1:0] irq_mask, next_irq_mask; // enables
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic next_irq;

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    seq_state_e state, next_state;
    logic [8:0] timer, next_timer; // half-cycle ticks left in interval
    logic [31:0] div, next_div; // mains half-cycle divider
    logic tick; // one-cycle pulse each half cycle
    logic [CUR_W-1:0] meas, next_meas; // last sample in weld
    logic err_high, next_err_high; // strictly above high limit
    logic err_low, next_err_low; // strictly below low limit
    logic init_d, next_init_d; // initiate edge detector
    valves_s next_valves;
    logic [CUR_W-1:0] next_display;
    logic [IRQ_BITS-1:0] ev; // events raised this cycle

    // decoded selections
    logic hold_mode, half_mode, mon_en;
    logic [CUR_W:0] hi_lim, lo_lim;
    logic out_hi, out_lo;
    logic [8:0] weld_len;
    logic bus_wr;

    assign hold_mode = (ctrl.proc_out == PO_HOLD_PART); // [RQ1]
    assign half_mode = (ctrl.proc_out == PO_HALF_CYCLE); // [RQ11]
    assign mon_en = (ctrl.reg_sel != CR_NONE); // [RQ13]
    assign hi_lim = eff_limit(cur_cfg[15:8], cur_cfg[7:0], 1'b1);
    assign lo_lim = eff_limit(cur_cfg[23:16], cur_cfg[7:0], 1'b0);
    // equality with a limit counts as inside the window
    assign out_hi = ({1'b0, meas} > hi_lim); // [RQ18]
    assign out_lo = ({1'b0, meas} < lo_lim); // [RQ18]
    // half-cycle mode counts weld in half cycles, else in full cycles
    assign weld_len = half_mode ? {1'b0, times[15:8]} : {times[15:8], 1'b0};
    assign tick = (div == 32'(HALF_CYCLE_DIV - 1));
    // a write takes effect at the edge where waitrequest is seen low
    assign bus_wr = avs_write && !avs_waitrequest;

    // ----------------------------------------------------------------
    // next state of the sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_meas = meas;
        next_err_high = err_high;
        next_err_low = err_low;
        next_init_d = initiate;
        next_display = display_value;
        next_div = tick ? 32'h0000_0000 : div + 32'h0000_0001;
        ev = '0;
        if (tick && timer != 9'h000) begin
            next_timer = timer - 9'h001;
        end
        case (state)
            ST_IDLE: begin
                // an unacknowledged error refuses new starts
                if (initiate && !init_d && !err_high && !err_low) begin
                    next_state = ST_SQUEEZE; // [RQ16]
                    next_timer = {times[7:0], 1'b0};
                    // a weld with no sample is judged on zero, not stale data
                    next_meas = '0;
                end
            end
            ST_SQUEEZE: begin
                if (timer == 9'h000) begin
                    next_state = ST_WELD;
                    next_timer = weld_len;
                end
            end
            ST_WELD: begin
                if (current_valid) begin
                    next_meas = measured_current;
                end
                if (timer == 9'h000) begin
                    next_state = ST_HOLD;
                    next_timer = {times[23:16], 1'b0};
                    if (ctrl.show_pct) begin
                        next_display = meas; // [RQ14]
                    end
                    if (mon_en && (out_hi || out_lo)) begin
                        next_err_high = out_hi; // [RQ17]
                        next_err_low = out_lo;
                        ev[IRQ_CUR_ERROR] = 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                if (timer == 9'h000) begin
                    ev[IRQ_WELD_DONE] = 1'b1;
                    // out of window in hold mode keeps the part clamped
                    if (hold_mode && (err_high || err_low)) begin
                        next_state = ST_HELD; // [RQ1] [RQ3]
                    end else begin
                        next_state = ST_IDLE; // [RQ3]
                    end
                end
            end
            ST_HELD: begin
                // lockout key, where fitted, gates the acknowledge
                if (panel_button &&
                    (!lockout_key_fitted || lockout_key_turned)) begin
                    next_state = ST_POR; // [RQ7] [RQ8]
                end
            end
            ST_POR: begin
                // one cycle with every valve off, sequencing state cleared
                next_state = ST_IDLE; // [RQ10]
                next_timer = 9'h000;
                next_meas = '0;
                next_err_high = 1'b0;
                next_err_low = 1'b0;
                next_display = '0;
                ev[IRQ_ERR_CLEARED] = 1'b1;
            end
            default: begin
                next_state = ST_POR;
            end
        endcase
        // error outside hold mode is acknowledged from idle
        if (state == ST_IDLE && (err_high || err_low) && panel_button &&
            (!lockout_key_fitted || lockout_key_turned)) begin
            next_state = ST_POR; // [RQ16] [RQ8]
        end
    end

    // valve drive follows the next state so outputs stay registered
    always_comb begin
        next_valves = '0;
        case (next_state)
            ST_SQUEEZE, ST_HOLD: begin
                next_valves.electrode_valve = 1'b1;
                next_valves.isolation_relay = 1'b1; // [RQ5]
            end
            ST_WELD: begin
                next_valves.electrode_valve = 1'b1;
                next_valves.isolation_relay = 1'b1; // [RQ5]
                next_valves.weld_fire = 1'b1;
            end
            ST_HELD: begin
                // contactor open so a shorted thyristor cannot weld
                next_valves.electrode_valve = 1'b1; // [RQ3] [RQ7]
                next_valves.isolation_relay = 1'b0; // [RQ9] [RQ5]
            end
            default: begin
                next_valves = '0; // [RQ10]
            end
        endcase
        // alarm follows any latched error until acknowledge
        if (next_state != ST_POR) begin
            next_valves.alarm_relay = next_err_high || next_err_low; // [RQ6] [RQ17]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            timer <= 9'h000;
            div <= 32'h0000_0000;
            meas <= '0;
            err_high <= 1'b0;
            err_low <= 1'b0;
            init_d <= 1'b0;
            valves <= '0;
            display_value <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            div <= next_div;
            meas <= next_meas;
            err_high <= next_err_high;
            err_low <= next_err_low;
            init_d <= next_init_d;
            valves <= next_valves;
            display_value <= next_display;
        end
    end

    // ----------------------------------------------------------------
    // next state of the register file and bus slave
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_times = times;
        next_cur_cfg = cur_cfg;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_readdata = avs_readdata;
        // one wait cycle, then release for exactly one edge
        next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
        if (bus_wr) begin
            case (avs_address)
                ADDR_CTRL: next_ctrl = ctrl_s'(avs_writedata[16:0]);
                ADDR_TIMES: next_times = avs_writedata[23:0];
                ADDR_CURRENT: next_cur_cfg = avs_writedata[23:0];
                ADDR_IRQ_STATUS: begin
                    next_irq_stat = irq_stat & ~avs_writedata[IRQ_BITS-1:0];
                end
                ADDR_IRQ_MASK: next_irq_mask = avs_writedata[IRQ_BITS-1:0];
                default: begin
                    next_ctrl = ctrl; // unmapped writes are ignored
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_irq_stat = next_irq_stat | ev;
        if (avs_read && avs_waitrequest) begin
            case (avs_address)
                ADDR_CTRL: next_readdata = {15'h0000, ctrl};
                ADDR_TIMES: next_readdata = {8'h00, times};
                ADDR_CURRENT: next_readdata = {8'h00, cur_cfg};
                ADDR_STATUS: begin
                    next_readdata = {8'h00, 8'(display_value), 8'(meas),
                                     3'b000, err_low, err_high, state};
                end
                ADDR_IRQ_STATUS: next_readdata = {29'h0, irq_stat};
                ADDR_IRQ_MASK: next_readdata = {29'h0, irq_mask};
                default: next_readdata = 32'h0000_0000;
            endcase
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= ctrl_s'(CTRL_RESET[16:0]);
            times <= TIMES_RESET[23:0];
            cur_cfg <= CURRENT_RESET[23:0];
            irq_stat <= '0;
            irq_mask <= '0;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
            irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            times <= next_times;
            cur_cfg <= next_cur_cfg;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
            irq <= next_irq;
        end
    end
endmodule : weld_current_limit_hold_sequencer
`default_nettype wire

// ==== bench/weld_seq_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// sequencer output checks
// ------------------------------------------------------------
module weld_seq_props (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic panel_button,
    input wire logic lockout_key_fitted,
    input wire logic lockout_key_turned,
    input wire weld_pkg::valves_s valves
);
    import weld_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // bus answer comes within two edges of the request
    a_bus_answer_bound: assert property (
        (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("bus answer late");
    a_iso_needs_head: assert property (
        valves.isolation_relay |-> valves.electrode_valve)
        else $error("isolation without electrode");
    a_fire_in_seq: assert property (
        valves.weld_fire |-> valves.isolation_relay)
        else $error("firing outside sequence");
    a_held_alarm_on: assert property (
        valves.electrode_valve && !valves.isolation_relay |->
        valves.alarm_relay) else $error("held part without alarm");
    a_alarm_needs_ack: assert property (
        $fell(valves.alarm_relay) |-> $past(panel_button) ||
        $past(panel_button, 2) || $past(panel_button, 3))
        else $error("alarm dropped without acknowledge");
    a_key_blocks_clear: assert property (
        lockout_key_fitted && !lockout_key_turned && valves.alarm_relay
        |=> valves.alarm_relay) else $error("cleared without key");
    a_clear_all_off: assert property (
        $fell(valves.alarm_relay) |-> valves == 4'h0)
        else $error("valves left on at clear");
    a_err_no_start: assert property (
        valves.alarm_relay && !valves.isolation_relay |=>
        !valves.isolation_relay) else $error("start while error latched");
    a_alarm_at_once: assert property (
        $rose(valves.alarm_relay) |-> valves.isolation_relay)
        else $error("alarm not raised in sequence");
    // main scenarios reached
    c_part_held: cover property (valves == 4'hA);
    c_error_cleared: cover property ($fell(valves.alarm_relay));
    c_weld_fired: cover property ($rose(valves.weld_fire));
endmodule : weld_seq_props
bind weld_current_limit_hold_sequencer weld_seq_props i_props (
    .core_clk(core_clk), .arst_n(arst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .panel_button(panel_button), .lockout_key_fitted(lockout_key_fitted),
    .lockout_key_turned(lockout_key_turned), .valves(valves));
`default_nettype wire

// ==== bench/weld_machine_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// welding head and current sensor
// ------------------------------------------------------------
module weld_machine_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire weld_pkg::valves_s valves, // one head, two contactor
    input wire logic [7:0] sensor_level, // current the next weld draws
    output logic [7:0] measured_current,
    output logic current_valid
);
    import weld_pkg::*;
    // sensor reports only while firing; otherwise the line wanders
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            measured_current <= 8'h00;
            current_valid <= 1'b0;
        end else if (valves.weld_fire) begin
            measured_current <= sensor_level;
            current_valid <= 1'b1;
        end else begin
            measured_current <= ~measured_current;
            current_valid <= 1'b0;
        end
    end
endmodule : weld_machine_model
`default_nettype wire

// ==== bench/weld_current_limit_hold_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module weld_current_limit_hold_sequencer_tb_top;
    import weld_pkg::*;
    localparam int DIV = 4; // short half cycle keeps the run brief
    logic core_clk, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, current_valid, irq, initiate = 1'b0;
    logic panel_button = 1'b0, lockout_key_fitted = 1'b0;
    logic lockout_key_turned = 1'b0;
    logic [7:0] measured_current, display_value, sensor_level = 8'h00;
    valves_s valves;
    int fail_count = 0, checks_done = 0, fires;
    weld_current_limit_hold_sequencer #(.HALF_CYCLE_DIV(DIV), .CUR_W(8))
    i_dut (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .initiate(initiate),
        .measured_current(measured_current), .current_valid(current_valid),
        .panel_button(panel_button), .lockout_key_fitted(lockout_key_fitted),
        .lockout_key_turned(lockout_key_turned), .valves(valves),
        .display_value(display_value), .irq(irq));
    weld_machine_model i_machine (.core_clk(core_clk), .arst_n(arst_n),
        .valves(valves), .sensor_level(sensor_level),
        .measured_current(measured_current), .current_valid(current_valid));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic test_done();
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic pulse_init();
        @(posedge core_clk) initiate <= 1'b1;
        @(posedge core_clk) initiate <= 1'b0;
    endtask : pulse_init
    // one sequence; counts firing cycles, ends after the contactor drops
    task automatic weld(input logic [7:0] c);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        fires = 0;
        sensor_level <= c;
        pulse_init();
        while (n < 300 && !(seen && valves.isolation_relay === 1'b0)) begin
            @(posedge core_clk);
            seen |= valves.isolation_relay === 1'b1;
            fires += int'(valves.weld_fire === 1'b1);
            n++;
        end
        if (n >= 300) fail_count++;
        repeat (3) @(posedge core_clk);
    endtask : weld
    task automatic press();
        @(posedge core_clk) panel_button <= 1'b1;
        repeat (2) @(posedge core_clk);
        panel_button <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : press
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl reset", rd, CTRL_RESET);
        bus(1'b0, 5'h18, 32'h0);
        check("unmapped read", rd, 32'h0);
        bus(1'b1, ADDR_TIMES, 32'h0001_0101); // weld 01, no off
        bus(1'b1, ADDR_CURRENT, 32'h0000_0064); // window 90..110
        bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
        bus(1'b1, ADDR_CTRL, 32'h0001_3326);
        weld(8'h6E); // upper edge of the window
        check("valves in window", 32'(valves), 32'h0);
        check("display", 32'(display_value), 32'h6E);
        check("full weld", 32'(fires > DIV), 32'h1);
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        check("done flag", rd[2:0], 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        bus(1'b1, ADDR_IRQ_STATUS, 32'h7);
        weld(8'h6F); // one above the high limit
        check("held", 32'(valves), 32'hA);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("held status", rd[4:0], 32'h0E);
        check("error irq", 32'(irq), 32'h1);
        pulse_init();
        repeat (20) @(posedge core_clk);
        check("init blocked", 32'(valves), 32'hA);
        lockout_key_fitted <= 1'b1;
        press();
        check("key not turned", 32'(valves), 32'hA);
        lockout_key_turned <= 1'b1;
        press();
        check("released", 32'(valves), 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("idle after clear", rd[4:0], 32'h0);
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        check("clear flags", rd[2:0], 32'h7);
        bus(1'b1, ADDR_IRQ_STATUS, 32'h7);
        // irq is registered at the write edge, so look one edge later
        @(posedge core_clk);
        check("irq cleared", 32'(irq), 32'h0);
        lockout_key_fitted <= 1'b0;
        bus(1'b1, ADDR_CTRL, 32'h0001_3300);
        weld(8'h5A); // lower edge of the window
        check("low edge", 32'(valves), 32'h0);
        weld(8'h59);
        check("low alarm", 32'(valves), 32'h2);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("low status", rd[4:0], 32'h10);
        pulse_init();
        repeat (20) @(posedge core_clk);
        check("low blocks", 32'(valves), 32'h2);
        press();
        check("low cleared", 32'(valves), 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h0001_0000);
        weld(8'hC8); // no sensor selected, so no limit check
        check("monitor off", 32'(valves), 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h0001_3309);
        weld(8'h64);
        check("half weld", 32'(fires <= DIV), 32'h1);
        test_done();
    end
endmodule : weld_current_limit_hold_sequencer_tb_top
`default_nettype wire
